// ### hdl/duf_top.sv
// dual serial port: main port with flow and modem lines, fixed-rate log port
`timescale 1ns/1ns

module duf_top #(
    parameter int RING_CYC = duf_pkg::RING_PULSE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // main port pins
    output logic mainSerialTx,
    input wire logic mainSerialRx,
    output logic clearToSendN,
    input wire logic requestToSendN,
    input wire logic terminalReadyN,
    output logic ring_alert_out,
    output logic carrier_present_out,
    // log port pins
    output logic log_serial_tx,
    input wire logic log_serial_rx,
    // rate control
    input wire logic baudLoad,
    input wire logic [3:0] baudSel,
    output logic [3:0] baudIdx,
    // main transmit stream
    input wire logic mainTxValid,
    input wire logic [7:0] mainTxData,
    output logic mainTxReady,
    // main receive stream
    output logic mainRxValid,
    output logic [7:0] mainRxData,
    input wire logic mainRxReady,
    output logic mainRxOverrun,
    output logic mainRxFrameErr,
    // log stream
    input wire logic logTxValid,
    input wire logic [7:0] logTxData,
    output logic logTxReady,
    output duf_pkg::duf_rx_s logRx,
    // modem status
    input wire logic unsolicited_report,
    input wire logic dataConnected,
    output logic hostReady,
    output logic sleepAllowed
);
    import duf_pkg::*;

    // indices past the rate table are not rates at all
    function automatic logic rateSupported(logic [3:0] idx);
        return idx < BAUD_COUNT;
    endfunction : rateSupported

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic rtsMeta;
        logic rtsSync;
        logic dtrMeta;
        logic dtrSync;
        logic [3:0] baudIdx;
        logic [DIV_W-1:0] divisor;
        logic holdValid;
        logic [7:0] holdData;
        logic overrun;
        logic frameErr;
        logic ctsN;
        logic [31:0] ringCnt;
        logic ringN;
        logic carrierN;
        logic hostReady;
        logic sleepAllowed;
    } duf_top_state_s;

    duf_top_state_s q, d;
    duf_rx_s mainRx;
    logic txAllow;

    // ****************************************
    // serial engines
    // ****************************************
    // main transmit is gated by the host's request line
    assign txAllow = !q.rtsSync;

    duf_serial mainPort (
        .clk(clk),
        .reset(reset),
        .divisor(q.divisor),
        .txAllow(txAllow),
        .txValid(mainTxValid),
        .txData(mainTxData),
        .txReady(mainTxReady),
        .txLine(mainSerialTx),
        .rxPin(mainSerialRx),
        .rxOut(mainRx)
    );

    // log port never gated by flow control
    duf_serial logPort (
        .clk(clk),
        .reset(reset),
        .divisor(DIV_DEBUG),
        .txAllow(1'b1),
        .txValid(logTxValid),
        .txData(logTxData),
        .txReady(logTxReady),
        .txLine(log_serial_tx),
        .rxPin(log_serial_rx),
        .rxOut(logRx)
    );

    // ****************************************
    // control and status
    // ****************************************
    always_comb begin
        d = q;
        // ****************************************
        // pin synchronisers
        // ****************************************
        d.rtsMeta = requestToSendN;
        d.rtsSync = q.rtsMeta;
        d.dtrMeta = terminalReadyN;
        d.dtrSync = q.dtrMeta;
        d.overrun = 1'b0;
        d.frameErr = mainRx.frameErr;

        // ****************************************
        // rate select
        // ****************************************
        // unsupported indices are ignored, the current rate stays
        if (baudLoad && rateSupported(baudSel)) begin
            d.baudIdx = baudSel;
            d.divisor = baudDivisor(baudRate(baudSel));
        end

        // ****************************************
        // receive hold and flow
        // ****************************************
        // one-character hold; a push in the pop cycle still lands
        if (q.holdValid && mainRxReady) begin
            d.holdValid = 1'b0;
        end
        if (mainRx.valid) begin
            if (d.holdValid) begin
                d.overrun = 1'b1;
            end else begin
                d.holdValid = 1'b1;
                d.holdData = mainRx.data;
            end
        end
        // host reaction is not instant: a character already in flight overruns
        d.ctsN = d.holdValid;

        // ****************************************
        // ring and modem lines
        // ****************************************
        // retriggerable low pulse
        if (unsolicited_report) begin
            d.ringCnt = 32'(RING_CYC - 1);
            d.ringN = 1'b0;
        end else if (q.ringCnt != '0) begin
            d.ringCnt = q.ringCnt - 1'b1;
        end else begin
            d.ringN = 1'b1;
        end

        // levels only; carrier takes one register stage, hostReady and sleepAllowed three with the synchroniser
        d.carrierN = !dataConnected;
        d.hostReady = !q.dtrSync;
        d.sleepAllowed = q.dtrSync;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.rtsMeta <= 1'b1;
            q.rtsSync <= 1'b1;
            q.dtrMeta <= 1'b1;
            q.dtrSync <= 1'b1;
            q.baudIdx <= BAUD_IDX_RESET;
            q.divisor <= DIV_RESET;
            q.ctsN <= 1'b0;
            // ring and carrier rest high, their inactive level
            q.ringN <= 1'b1;
            q.carrierN <= 1'b1;
            q.sleepAllowed <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output driven here is a field of the state register; the serial pins and streams come from the engines
    assign clearToSendN = q.ctsN;
    assign ring_alert_out = q.ringN;
    assign carrier_present_out = q.carrierN;
    assign baudIdx = q.baudIdx;
    assign mainRxValid = q.holdValid;
    assign mainRxData = q.holdData;
    assign mainRxOverrun = q.overrun;
    assign mainRxFrameErr = q.frameErr;
    assign hostReady = q.hostReady;
    assign sleepAllowed = q.sleepAllowed;

endmodule : duf_top

// ### common/duf_pkg.sv
// shared constants, types and rate arithmetic for the dual serial port block
package duf_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_HZ = 125_000_000;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int RING_PULSE_MS = 120;
    localparam int RING_PULSE_CYC = RING_PULSE_MS * (CLK_HZ / 1000);

    // ****************************************
    // rates
    // ****************************************
    localparam int DIV_W = 16;
    localparam logic [3:0] BAUD_COUNT = 4'h9;
    localparam logic [3:0] BAUD_IDX_RESET = 4'h5;
    localparam int DEBUG_BAUD = 115200;

    // index 0..8 maps to the nine supported main port rates
    function automatic int baudRate(logic [3:0] idx);
        int rate;
        rate = 0;
        unique case (idx)
            4'h0: rate = 4800;
            4'h1: rate = 9600;
            4'h2: rate = 19200;
            4'h3: rate = 38400;
            4'h4: rate = 57600;
            4'h5: rate = 115200;
            4'h6: rate = 230400;
            4'h7: rate = 460800;
            4'h8: rate = 921600;
            default: rate = 115200;
        endcase
        return rate;
    endfunction : baudRate

    // clocks per oversample tick, rounded to nearest
    function automatic logic [DIV_W-1:0] baudDivisor(int rate);
        int d;
        d = (CLK_HZ + (rate * OVERSAMPLE) / 2) / (rate * OVERSAMPLE);
        return DIV_W'(d);
    endfunction : baudDivisor

    localparam logic [DIV_W-1:0] DIV_RESET = baudDivisor(baudRate(BAUD_IDX_RESET));
    localparam logic [DIV_W-1:0] DIV_DEBUG = baudDivisor(DEBUG_BAUD);

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} duf_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} duf_rx_e;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic frameErr;
    } duf_rx_s;

endpackage : duf_pkg

// ### hdl/duf_serial.sv
// one serial engine: 16x oversampled receiver and gated transmitter
`timescale 1ns/1ns
module duf_serial (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // rate and flow
    input wire logic [duf_pkg::DIV_W-1:0] divisor,
    input wire logic txAllow,
    // transmit stream
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    // pins
    output logic txLine,
    input wire logic rxPin,
    // receive result
    output duf_pkg::duf_rx_s rxOut
);
    import duf_pkg::*;

    typedef struct packed {
        logic rxMeta;
        logic rxSync;
        logic [DIV_W-1:0] tickCnt;
        logic tick;
        duf_tx_e txState;
        logic [3:0] txOs;
        logic [2:0] txBit;
        logic [7:0] txShift;
        logic txLine;
        logic txReady;
        duf_rx_e rxState;
        logic [3:0] rxOs;
        logic [2:0] rxBit;
        logic [7:0] rxShift;
        duf_rx_s rx;
    } duf_ser_state_s;

    duf_ser_state_s q, d;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.rxMeta = rxPin;
        d.rxSync = q.rxMeta;
        d.tick = 1'b0;
        d.rx.valid = 1'b0;
        d.rx.frameErr = 1'b0;
        // a rate change takes effect at the next tick reload
        if (q.tickCnt == '0) begin
            d.tickCnt = divisor - 1'b1;
            d.tick = 1'b1;
        end else begin
            d.tickCnt = q.tickCnt - 1'b1;
        end

        // transmit: start, eight bits lsb first, stop
        unique case (q.txState)
            TX_IDLE: begin
                if (txValid && q.txReady) begin
                    d.txShift = txData;
                    d.txState = TX_START;
                    d.txLine = 1'b0;
                    d.txOs = '0;
                end
            end
            TX_START, TX_DATA, TX_STOP: begin
                if (q.tick) begin
                    d.txOs = q.txOs + 1'b1;
                    if (q.txOs == OS_LAST) begin
                        if (q.txState == TX_START) begin
                            d.txState = TX_DATA;
                            d.txLine = q.txShift[0];
                            d.txBit = '0;
                        end else if (q.txState == TX_DATA && q.txBit != BIT_LAST) begin
                            d.txShift = {1'b0, q.txShift[7:1]};
                            d.txLine = q.txShift[1];
                            d.txBit = q.txBit + 1'b1;
                        end else if (q.txState == TX_DATA) begin
                            d.txState = TX_STOP;
                            d.txLine = 1'b1;
                        end else begin
                            d.txState = TX_IDLE;
                        end
                    end
                end
            end
        endcase
        // new characters wait while the host holds its request inactive
        d.txReady = (d.txState == TX_IDLE) && txAllow;

        // receive: confirm start at mid bit, then sample every 16 ticks
        unique case (q.rxState)
            RX_IDLE: begin
                if (!q.rxSync) begin
                    d.rxState = RX_START;
                    d.rxOs = '0;
                end
            end
            RX_START: begin
                if (q.tick) begin
                    d.rxOs = q.rxOs + 1'b1;
                    if (q.rxOs == OS_MID) begin
                        d.rxState = q.rxSync ? RX_IDLE : RX_DATA;
                        d.rxOs = '0;
                        d.rxBit = '0;
                    end
                end
            end
            RX_DATA, RX_STOP: begin
                if (q.tick) begin
                    d.rxOs = q.rxOs + 1'b1;
                    if (q.rxOs == OS_LAST) begin
                        if (q.rxState == RX_DATA) begin
                            d.rxShift = {q.rxSync, q.rxShift[7:1]};
                            d.rxBit = q.rxBit + 1'b1;
                            if (q.rxBit == BIT_LAST) begin
                                d.rxState = RX_STOP;
                            end
                        end else begin
                            d.rxState = RX_IDLE;
                            // low stop bit: frame dropped, only the error pulses
                            d.rx.valid = q.rxSync;
                            d.rx.frameErr = !q.rxSync;
                            d.rx.data = q.rxShift;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.rxMeta <= 1'b1;
            q.rxSync <= 1'b1;
            q.txLine <= 1'b1;
            q.txState <= TX_IDLE;
            q.rxState <= RX_IDLE;
        end else begin
            q <= d;
        end
    end

    assign txReady = q.txReady;
    assign txLine = q.txLine;
    assign rxOut = q.rx;

endmodule : duf_serial

// ### dv/duf_top_asserts.sv
// port assertions for the dual serial port block
`timescale 1ns/1ns
module duf_asserts #(
    parameter int RING_CYC = 20
) (
    // clock, reset and main port
    input wire logic clk,
    input wire logic reset,
    input wire logic mainSerialTx,
    input wire logic clearToSendN,
    input wire logic requestToSendN,
    input wire logic mainTxValid,
    input wire logic mainTxReady,
    input wire logic mainRxValid,
    // rate and modem lines
    input wire logic baudLoad,
    input wire logic [3:0] baudSel,
    input wire logic [3:0] baudIdx,
    input wire logic unsolicited_report,
    input wire logic ring_alert_out,
    input wire logic dataConnected,
    input wire logic carrier_present_out
);
    int ringCnt_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // low cycles since the last report, so a retrigger restarts the span
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ringCnt_q <= 0;
        end else if (unsolicited_report) begin
            ringCnt_q <= 0;
        end else if (!ring_alert_out) begin
            ringCnt_q <= ringCnt_q + 1;
        end
    end
    a_ring_start: assert property (unsolicited_report |=> !ring_alert_out && ringCnt_q == 0)
        else $error("ring did not start on report");
    a_ring_span: assert property ($rose(ring_alert_out) |-> ringCnt_q == RING_CYC)
        else $error("ring low span wrong");
    a_rate_load: assert property (baudLoad && baudSel < 4'h9 |=> baudIdx == $past(baudSel))
        else $error("rate index not loaded");
    a_rate_hold: assert property (!(baudLoad && baudSel < 4'h9) |=> $stable(baudIdx))
        else $error("rate index moved");
    a_cts_full: assert property (clearToSendN == mainRxValid)
        else $error("cts does not follow hold");
    a_rts_gate: assert property (requestToSendN [*6] |-> !mainTxReady)
        else $error("start sent while held off");
    a_tx_start: assert property (mainTxValid && mainTxReady |=> !mainTxReady && !mainSerialTx)
        else $error("no start bit after take");
    a_carrier_follow: assert property (1'b1 |=> carrier_present_out == !$past(dataConnected))
        else $error("carrier does not follow");
endmodule : duf_asserts

bind duf_top duf_asserts #(.RING_CYC(RING_CYC)) i_duf_asserts (.clk(clk), .reset(reset),
    .mainSerialTx(mainSerialTx), .clearToSendN(clearToSendN), .requestToSendN(requestToSendN),
    .mainTxValid(mainTxValid), .mainTxReady(mainTxReady), .mainRxValid(mainRxValid), .baudLoad(baudLoad),
    .baudSel(baudSel), .baudIdx(baudIdx), .unsolicited_report(unsolicited_report),
    .ring_alert_out(ring_alert_out), .dataConnected(dataConnected), .carrier_present_out(carrier_present_out));

// ### dv/duf_host_model.sv
// host side serial model: frame decoder and frame sender
`timescale 1ns/1ns
module duf_host_model (
    // clock
    input wire logic clk,
    // serial pins
    input wire logic devTx,
    output logic devRx
);
    int bitCyc = 1088;
    logic [7:0] gotByte = 8'h00;
    int gotCount = 0;
    initial devRx = 1'b1;
    // mid-bit sampling; only frames with a high stop bit are counted
    always begin
        @(negedge devTx);
        repeat (bitCyc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bitCyc) @(posedge clk);
            gotByte[i] = devTx;
        end
        repeat (bitCyc) @(posedge clk);
        if (devTx) gotCount++;
    end
    // a low stopBit makes a broken frame on purpose
    task automatic sendByte(input logic [7:0] b, input logic stopBit);
        logic [9:0] f;
        f = {stopBit, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 devRx = f[i];
            // a short broken stop bit keeps the receiver from seeing a fresh start
            repeat ((i == 9 && !stopBit) ? bitCyc * 3 / 4 : bitCyc - 1) @(posedge clk);
        end
        @(posedge clk);
        #1 devRx = 1'b1;
    endtask : sendByte
endmodule : duf_host_model

// ### dv/test_duf_top.sv
// self-checking bench for the dual serial port block
`timescale 1ns/1ns
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: %s", $time, m); end end
module test_duf_top;
    import duf_pkg::*;
    localparam int RING = 20;
    int err_count = 0;
    int cmp_count = 0;
    int ovrCnt = 0;
    int ferCnt = 0;
    int logCnt = 0;
    int logFerCnt = 0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic requestToSendN = 1'b0, terminalReadyN = 1'b1, baudLoad = 1'b0, mainTxValid = 1'b0, mainRxReady = 1'b0;
    logic logTxValid = 1'b0, unsolicited_report = 1'b0, dataConnected = 1'b0;
    logic [3:0] baudSel = 4'h0;
    logic [7:0] mainTxData = 8'h00, logTxData = 8'h00;
    logic mainSerialTx, mainSerialRx, clearToSendN, ring_alert_out, carrier_present_out, log_serial_tx;
    logic log_serial_rx, mainTxReady, mainRxValid, mainRxOverrun, mainRxFrameErr, logTxReady, hostReady;
    logic sleepAllowed;
    logic [3:0] baudIdx;
    logic [7:0] mainRxData;
    duf_rx_s logRx;

    always #4 clk = ~clk;

    duf_top #(.RING_CYC(RING)) i_duf_top (.clk(clk), .reset(reset), .mainSerialTx(mainSerialTx),
        .mainSerialRx(mainSerialRx), .clearToSendN(clearToSendN), .requestToSendN(requestToSendN),
        .terminalReadyN(terminalReadyN), .ring_alert_out(ring_alert_out), .carrier_present_out(carrier_present_out),
        .log_serial_tx(log_serial_tx), .log_serial_rx(log_serial_rx), .baudLoad(baudLoad), .baudSel(baudSel),
        .baudIdx(baudIdx), .mainTxValid(mainTxValid), .mainTxData(mainTxData), .mainTxReady(mainTxReady),
        .mainRxValid(mainRxValid), .mainRxData(mainRxData), .mainRxReady(mainRxReady), .mainRxOverrun(mainRxOverrun),
        .mainRxFrameErr(mainRxFrameErr), .logTxValid(logTxValid), .logTxData(logTxData), .logTxReady(logTxReady),
        .logRx(logRx), .unsolicited_report(unsolicited_report), .dataConnected(dataConnected),
        .hostReady(hostReady), .sleepAllowed(sleepAllowed));
    duf_host_model i_main_host (.clk(clk), .devTx(mainSerialTx), .devRx(mainSerialRx));
    duf_host_model i_log_host (.clk(clk), .devTx(log_serial_tx), .devRx(log_serial_rx));

    // one-cycle pulses would be missed by the blocking host tasks; counted mid-cycle where settled
    always @(negedge clk) begin
        ovrCnt += (mainRxOverrun === 1'b1);
        ferCnt += (mainRxFrameErr === 1'b1);
        logCnt += (logRx.valid === 1'b1);
        logFerCnt += (logRx.frameErr === 1'b1);
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic testReset();
        `CHK(baudIdx, 4'h5, "rate index after reset")
        `CHK(clearToSendN, 1'b0, "cts after reset")
        `CHK(ring_alert_out, 1'b1, "ring idle")
        `CHK(carrier_present_out, 1'b1, "carrier idle")
        `CHK(sleepAllowed, 1'b1, "sleep with terminal-ready high")
    endtask : testReset

    // hold keeps request-to-send off for a while with the char offered
    task automatic testTx(input logic isLog, input logic [7:0] b, input logic hold);
        int n, c0;
        logic lowSeen;
        n = 0;
        lowSeen = 1'b0;
        c0 = isLog ? i_log_host.gotCount : i_main_host.gotCount;
        requestToSendN = hold;
        repeat (8) @(posedge clk);
        #1;
        mainTxValid = !isLog;
        logTxValid = isLog;
        mainTxData = b;
        logTxData = b;
        if (hold) begin
            // outlast any slow tick reload left behind by the rate changes
            repeat (2000) begin
                @(posedge clk);
                lowSeen |= !mainSerialTx;
            end
            `CHK(lowSeen, 1'b0, "start sent while held off")
            #1 requestToSendN = 1'b0;
        end
        do begin
            @(posedge clk);
            n++;
        end while ((isLog ? logTxReady : mainTxReady) !== 1'b1 && n < 20000);
        #1;
        mainTxValid = 1'b0;
        logTxValid = 1'b0;
        n = 0;
        while ((isLog ? i_log_host.gotCount : i_main_host.gotCount) == c0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        `CHK(isLog ? i_log_host.gotCount : i_main_host.gotCount, c0 + 1, "frame counted")
        `CHK(isLog ? i_log_host.gotByte : i_main_host.gotByte, b, "byte on serial line")
        repeat (1100) @(posedge clk);
    endtask : testTx

    task automatic loadRate(input logic [3:0] sel);
        logic [3:0] want;
        want = (sel < 4'h9) ? sel : baudIdx;
        @(posedge clk);
        #1;
        baudLoad = 1'b1;
        baudSel = sel;
        @(posedge clk);
        #1 baudLoad = 1'b0;
        `CHK(baudIdx, want, "rate index")
    endtask : loadRate

    task automatic testRx();
        int o, f;
        o = ovrCnt;
        f = ferCnt;
        i_main_host.sendByte(8'h3C, 1'b1);
        repeat (4) @(posedge clk);
        `CHK(mainRxValid, 1'b1, "char held")
        `CHK(mainRxData, 8'h3C, "char data")
        `CHK(clearToSendN, 1'b1, "cts while hold full")
        i_main_host.sendByte(8'hC3, 1'b1);
        repeat (4) @(posedge clk);
        `CHK(ovrCnt, o + 1, "overrun pulse")
        `CHK(mainRxData, 8'h3C, "held char kept")
        #1 mainRxReady = 1'b1;
        @(posedge clk);
        #1 mainRxReady = 1'b0;
        repeat (2) @(posedge clk);
        `CHK(clearToSendN, 1'b0, "cts after pop")
        i_main_host.sendByte(8'h55, 1'b0);
        repeat (4) @(posedge clk);
        `CHK(ferCnt, f + 1, "frame error pulse")
        `CHK(mainRxValid, 1'b0, "broken frame dropped")
    endtask : testRx

    task automatic testModem(input logic retrig);
        int lowN;
        lowN = 0;
        @(posedge clk);
        #1;
        dataConnected = 1'b1;
        terminalReadyN = 1'b0;
        unsolicited_report = 1'b1;
        for (int k = 0; k < 80; k++) begin
            @(posedge clk);
            #1;
            lowN += (ring_alert_out === 1'b0);
            unsolicited_report = retrig && k == 9;
        end
        `CHK(lowN, retrig ? 2 * RING - 10 : RING, "ring low span")
        `CHK(carrier_present_out, 1'b0, "carrier with connection")
        `CHK(hostReady, 1'b1, "terminal-ready seen")
        `CHK(sleepAllowed, 1'b0, "sleep blocked")
        dataConnected = 1'b0;
        terminalReadyN = 1'b1;
    endtask : testModem

    task automatic testLogRx();
        int c0, f0;
        c0 = logCnt;
        f0 = logFerCnt;
        i_log_host.sendByte(8'h96, 1'b1);
        repeat (4) @(posedge clk);
        `CHK(logCnt, c0 + 1, "log char arrived")
        `CHK(logRx.data, 8'h96, "log char data")
        i_log_host.sendByte(8'h69, 1'b0);
        repeat (4) @(posedge clk);
        `CHK(logFerCnt, f0 + 1, "log broken frame flagged")
        `CHK(logCnt, c0 + 1, "log broken frame dropped")
    endtask : testLogRx

    initial begin
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        testReset();
        testTx(1'b0, 8'h5A, 1'b0);
        testTx(1'b1, 8'hA6, 1'b0);
        testLogRx();
        for (int i = 0; i < 10; i++) begin
            loadRate(4'(i));
        end
        loadRate(4'hF);
        loadRate(4'h8);
        i_main_host.bitCyc = 128;
        testTx(1'b0, 8'hE1, 1'b1);
        testRx();
        testModem(1'b0);
        testModem(1'b1);
        test_done();
    end

    // expected run is near 53000 cycles
    initial begin
        #800000;
        err_count++;
        test_done();
    end
endmodule : test_duf_top
